/* File: spi_port_pkg.sv */
/*
  Constants for the synchronous serial port in SPI mode: register offsets,
  field positions, reset values, mode codes and divider counts.
  Assumes an 8-bit register port and a 200 MHz system clock.
*/
package spi_port_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_BUF = 8'h13;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_DIR_C = 8'h87;
  localparam logic [7:0] OFS_DIR_A = 8'h85;
  localparam logic [7:0] OFS_STAT = 8'h94;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h0d;
  localparam logic [7:0] OFS_IRQ_EN = 8'h8c;

  // Control register fields
  localparam int CTRL_WCOL = 7;
  localparam int CTRL_OVF = 6;
  localparam int CTRL_EN = 5;
  localparam int CTRL_CPOL = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Direction bits: port C 3/4/5 and port A 5
  localparam int DIR_SCK = 3;
  localparam int DIR_SDI = 4;
  localparam int DIR_SDO = 5;
  localparam int DIR_SS = 5;
  localparam logic [7:0] DIR_RST = 8'hff;

  // Status register fields
  localparam int STAT_BF = 0;
  localparam logic [7:0] STAT_RST = 8'h00;

  // Interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVF = 1;
  localparam int IRQ_WCOL = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // Mode field codes (control bits 3:0)
  typedef enum logic [3:0]
  {
    MODE_M_DIV4 = 4'h0,
    MODE_M_DIV16 = 4'h1,
    MODE_M_DIV64 = 4'h2,
    MODE_M_DIV128 = 4'h3,
    MODE_S_SS = 4'h4,
    MODE_S_NOSS = 4'h5
  } mode_t;

  // Half periods of the master serial clock, in system clock cycles
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;

  localparam logic [3:0] BITS_PER_WORD = 4'h8;

  typedef enum logic
  {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } xfer_st_t;

endpackage

/* File: spi_core_if.sv */
/*
  Bundle between the register side of the serial port and its shift engine.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface spi_core_if;
  logic [7:0] tx_data;
  logic [7:0] rx_data;
  logic load;
  logic done;
  logic busy;
  logic master;
  logic cpol;
  logic ss_use;
  logic xfer_rst;
  logic tick;
  logic sck_in;
  logic sdi_in;
  logic ss_n_in;
  logic sck_out;
  logic serial_data_out_pin;

  modport ctrl (
    output tx_data, load, master, cpol, ss_use, xfer_rst, tick, sck_in, sdi_in, ss_n_in,
    input rx_data, done, busy, sck_out, serial_data_out_pin
  );
  modport engine (
    input tx_data, load, master, cpol, ss_use, xfer_rst, tick, sck_in, sdi_in, ss_n_in,
    output rx_data, done, busy, sck_out, serial_data_out_pin
  );
endinterface

/* File: spi_shift_engine.sv */
/*
  Shift engine: moves one byte out and one byte in, MSB first.
  Assumes serial inputs arrive already synchronised to sys_clk.
*/
`timescale 1ns/1ps
module spi_shift_engine
  import spi_port_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Control side
  spi_core_if.engine core
);
  import spi_port_pkg::*;

  xfer_st_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] cnt_reg;
  logic sample_reg;
  logic sck_reg;
  logic sck_prev_reg;

  // Data leaves on the trailing edge; a slave takes it on the leading edge
  wire logic s_lead = (core.sck_in != sck_prev_reg) && (core.sck_in != core.cpol);
  wire logic s_trail = (core.sck_in != sck_prev_reg) && (core.sck_in == core.cpol);
  wire logic m_lead = core.tick && (state_reg == ST_SHIFT) && (sck_reg == core.cpol);
  wire logic m_trail = core.tick && (state_reg == ST_SHIFT) && (sck_reg != core.cpol);
  wire logic lead = core.master ? m_lead : s_lead;
  wire logic trail = core.master ? m_trail : (s_trail && state_reg == ST_SHIFT);
  wire logic last = (cnt_reg == BITS_PER_WORD - 4'h1);
  // Master takes data on the trailing edge: the input synchroniser would make a
  // leading-edge sample one bit stale at the fastest rate
  wire logic in_bit = core.master ? core.sdi_in : sample_reg;
  wire logic m_done = trail && (cnt_reg == BITS_PER_WORD);
  wire logic s_done = lead && last;

  assign core.serial_data_out_pin = shift_reg[7];
  assign core.sck_out = core.master ? sck_reg : core.cpol;
  assign core.busy = (state_reg == ST_SHIFT);
  assign core.done = core.master ? m_done : s_done;
  assign core.rx_data = {shift_reg[6:0], core.sdi_in};

  always_ff @(posedge sys_clk)
  begin
    sck_prev_reg <= core.sck_in;
    if (sys_rst || core.xfer_rst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      sck_reg <= core.cpol;
      sample_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == ST_IDLE)
        sck_reg <= core.cpol;
      else if (core.master && core.tick)
        sck_reg <= ~sck_reg;
      if (core.load && core.master && state_reg == ST_IDLE)
        state_reg <= ST_SHIFT;
      if (lead)
      begin
        sample_reg <= core.sdi_in;
        cnt_reg <= cnt_reg + 4'h1;
        state_reg <= ST_SHIFT;
      end
      if (trail)
      begin
        if (cnt_reg == BITS_PER_WORD)
        begin
          cnt_reg <= 4'h0;
          state_reg <= ST_IDLE;
        end
      end
    end
  end

  // A high select only restarts the transfer, so a byte loaded beforehand survives
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      shift_reg <= 8'h00;
    else if (core.load && state_reg == ST_IDLE)
      shift_reg <= core.tx_data;
    else if (trail && !core.xfer_rst)
      shift_reg <= {shift_reg[6:0], in_bit};
  end

  cnt_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cnt_reg <= BITS_PER_WORD)
    else $error("bit count above eight");

  idle_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    core.done |-> cnt_reg == (core.master ? BITS_PER_WORD : BITS_PER_WORD - 4'h1))
    else $error("done without eighth edge");
endmodule

/* File: spi_port.sv */
/*
  Synchronous serial port, SPI mode: register port, pin handling, clock divider,
  interrupt logic and the shift engine instance.
  Assumes an 8-bit register master that never waits and external pins that
  are asynchronous to sys_clk.
*/
// Implementation choice: strobed register access.
`timescale 1ns/1ps
// Notes on behaviour
// - One byte shifts out and one in together, timed by the serial clock.
// - A transfer uses data out, data in and serial clock lines.
// - A slave may also use an active-low select framed by the master.
// - Master drives the serial clock; slave takes it as an input.
// - Polarity bit picks which clock edges launch and sample data.
// - The rate setting applies only in master mode.
// - Honouring the select input is an option meaningful only for slaves.
// - Control bits four to zero choose role, polarity, rate and select.
// - The port works only while control bit five is set.
// - Enable hands the four pins to the serial port.
// - Status bit zero is set while a received byte waits.
// - Start and stop status bits are zero after reset and when disabled.
// - Slave with select enabled resets its transfer while select is high.
module spi_port
  import spi_port_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [spi_port_pkg::ADDR_W-1:0] addr,
  input wire logic [spi_port_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [spi_port_pkg::DATA_W-1:0] rdata,
  // Interrupt
  output logic irq,
  // Serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic ss_n_i
);
  import spi_port_pkg::*;

  spi_core_if core ();

  logic [7:0] ctrl_reg;
  logic [7:0] dir_c_reg;
  logic [7:0] dir_a_reg;
  logic [7:0] buf_reg;
  logic bf_reg;
  logic [IRQ_W-1:0] irq_st_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [7:0] rdata_reg;
  logic [6:0] div_reg;
  logic [1:0] sck_sync_reg;
  logic [1:0] sdi_sync_reg;
  logic [1:0] ss_sync_reg;

  function automatic logic is_master(input logic [3:0] mode);
    is_master = (mode <= MODE_M_DIV128);
  endfunction

  function automatic logic [6:0] half_count(input logic [3:0] mode);
    case (mode)
      MODE_M_DIV4: half_count = HALF_DIV4;
      MODE_M_DIV16: half_count = HALF_DIV16;
      MODE_M_DIV64: half_count = HALF_DIV64;
      default: half_count = HALF_DIV128;
    endcase
  endfunction

  // Control decode
  wire logic [3:0] mode = ctrl_reg[3:0];
  wire logic enabled = ctrl_reg[CTRL_EN];
  wire logic master = is_master(mode);
  wire logic ss_use = (mode == MODE_S_SS);
  wire logic ss_high = ss_sync_reg[1];
  wire logic ss_idle = !master && ss_use && ss_high;

  // Register access decode
  wire logic wr_buf = wr && (addr == OFS_BUF);
  wire logic wr_ctrl = wr && (addr == OFS_CTRL);
  wire logic rd_buf = rd && (addr == OFS_BUF);
  wire logic wr_irq_clr = wr && (addr == OFS_IRQ_CLR);
  wire logic collide = wr_buf && core.busy;
  wire logic overflow = core.done && bf_reg;
  wire logic [IRQ_W-1:0] irq_set = {collide, overflow, core.done};

  // Start/stop detection exists only in the two-wire mode, so they stay zero
  wire logic [7:0] status = {2'b00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, bf_reg};

  wire logic [7:0] rd_mux =
    (addr == OFS_BUF) ? buf_reg :
    (addr == OFS_CTRL) ? ctrl_reg :
    (addr == OFS_STAT) ? status :
    (addr == OFS_DIR_C) ? dir_c_reg :
    (addr == OFS_DIR_A) ? dir_a_reg :
    (addr == OFS_IRQ_STAT) ? {5'h00, irq_st_reg} :
    (addr == OFS_IRQ_EN) ? {5'h00, irq_en_reg} :
    8'h00;

  // Sticky error bits: hardware set beats a software clear
  wire logic wcol_next = collide || (ctrl_reg[CTRL_WCOL] && !(wr_ctrl && !wdata[CTRL_WCOL]));
  wire logic ovf_next = overflow || (ctrl_reg[CTRL_OVF] && !(wr_ctrl && !wdata[CTRL_OVF]));
  wire logic [5:0] cfg_next = wr_ctrl ? wdata[5:0] : ctrl_reg[5:0];
  wire logic bf_next = core.done || (bf_reg && !rd_buf);
  wire logic [IRQ_W-1:0] irq_st_next =
    irq_set | (irq_st_reg & ~(wr_irq_clr ? wdata[IRQ_W-1:0] : {IRQ_W{1'b0}}));

  // Divider runs during any transfer; only a master transfer takes its tick
  wire logic div_end = (div_reg == half_count(mode) - 7'h01);

  // Engine hookup
  assign core.tx_data = wdata;
  assign core.load = wr_buf && !core.busy && enabled;
  assign core.master = master;
  assign core.cpol = ctrl_reg[CTRL_CPOL];
  assign core.ss_use = ss_use;
  assign core.xfer_rst = !enabled || ss_idle;
  assign core.tick = master && core.busy && div_end;
  assign core.sck_in = sck_sync_reg[1];
  assign core.sdi_in = sdi_sync_reg[1];
  assign core.ss_n_in = ss_high;

  // Pins belong to the port only while enabled
  assign sck_o = enabled ? core.sck_out : 1'b0;
  assign sck_oe = enabled && master && !dir_c_reg[DIR_SCK];
  assign sdo_o = enabled ? core.serial_data_out_pin : 1'b0;
  assign sdo_oe = enabled && !dir_c_reg[DIR_SDO] && !ss_idle;
  assign rdata = rdata_reg;
  assign irq = |(irq_st_reg & irq_en_reg);

  spi_shift_engine engine_u (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .core(core.engine)
  );

  always_ff @(posedge sys_clk)
  begin
    sck_sync_reg <= {sck_sync_reg[0], sck_i};
    sdi_sync_reg <= {sdi_sync_reg[0], sdi_i};
    ss_sync_reg <= {ss_sync_reg[0], ss_n_i};
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl_reg <= CTRL_RST;
      dir_c_reg <= DIR_RST;
      dir_a_reg <= DIR_RST;
      bf_reg <= 1'b0;
      irq_st_reg <= IRQ_RST;
      irq_en_reg <= IRQ_RST;
      rdata_reg <= 8'h00;
    end
    else
    begin
      ctrl_reg <= {wcol_next, ovf_next, cfg_next};
      bf_reg <= bf_next;
      irq_st_reg <= irq_st_next;
      rdata_reg <= rd ? rd_mux : 8'h00;
      if (wr && addr == OFS_DIR_C)
        dir_c_reg <= wdata;
      if (wr && addr == OFS_DIR_A)
        dir_a_reg <= wdata;
      if (wr && addr == OFS_IRQ_EN)
        irq_en_reg <= wdata[IRQ_W-1:0];
    end
  end

  // A full buffer is not overwritten; the overflow flag reports the lost byte
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      buf_reg <= 8'h00;
    else if (core.done && !bf_reg)
      buf_reg <= core.rx_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !core.busy || div_end)
      div_reg <= 7'h00;
    else
      div_reg <= div_reg + 7'h01;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence stat_read_s;
    rd && addr == OFS_STAT;
  endsequence

  sequence master_load_s;
    core.load && master;
  endsequence

  buf_full_set_a: assert property (core.done |=> bf_reg)
    else $error("buffer full not set after byte");

  stat_value_a: assert property (stat_read_s |=> rdata[STAT_BF] == $past(bf_reg))
    else $error("status read lost buffer full");

  stat_top_zero_a: assert property (stat_read_s |=> rdata[7:3] == 5'h00)
    else $error("status upper bits not zero");

  pins_released_a: assert property (!enabled |-> !sck_oe && !sdo_oe)
    else $error("pins driven while disabled");

  slave_clk_in_a: assert property (!master |-> !sck_oe)
    else $error("slave drives serial clock");

  select_reset_a: assert property (enabled && ss_idle |=> !core.busy)
    else $error("transfer survives high select");

  idle_polarity_a: assert property (enabled && master && !core.busy
    |-> core.sck_out == core.cpol)
    else $error("serial clock idle level wrong");

  xfer_start_a: assert property (master_load_s |=> core.busy [*2])
    else $error("master transfer did not start");

  stat_readonly_a: assert property (wr && addr == OFS_STAT && !core.done
    |=> bf_reg == $past(bf_reg))
    else $error("status changed by write");
endmodule

/* File: spi_far_end.sv */
/*
  Far end of the serial link: an SPI slave while the port is master, or an
  SPI master with a 48 ns clock while the port is slave.
  Assumes the bench resolves the clock wire from both drivers.
*/
`timescale 1ns/1ps
module spi_far_end (
  // Resolved wire levels
  input wire logic sck_w,
  input wire logic mosi,
  // Far side drive
  output logic sck_m,
  output logic miso,
  output logic ss_n
);
  logic cpol;
  logic [7:0] tx;
  logic [7:0] rx;
  initial
  begin
    cpol = 1'b0;
    sck_m = 1'b0;
    miso = 1'b0;
    ss_n = 1'b1;
    tx = 8'h00;
    rx = 8'h00;
  end
  // Leading edge samples, trailing edge launches the next bit, MSB first
  always @(sck_w)
    if (sck_w !== cpol)
      rx = {rx[6:0], mosi};
    else
    begin
      tx = {tx[6:0], ~tx[7]};
      miso = tx[7];
    end
  task automatic load(input logic p, input logic [7:0] d);
    cpol = p;
    sck_m = p;
    #1;
    tx = d;
    rx = 8'h00;
    miso = d[7];
  endtask
  // Clock stands still outside frames; a released data line shows no stale bit
  task automatic frame(input int n, input logic sel);
    ss_n = ~sel;
    #30;
    repeat (n)
    begin
      #24 sck_m = ~cpol;
      #24 sck_m = cpol;
    end
    #30;
    ss_n = 1'b1;
    miso = ~miso;
  endtask
endmodule

/* File: spi_port_tb_top.sv */
/*
  Self-checking bench: register map, master transfers at all four rates,
  slave transfers with and without select, disable.
  Assumes the far end model spi_far_end.
*/
`timescale 1ns/1ps
module spi_port_tb_top;
  import spi_port_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic irq, sck_o, sck_oe, sdo_o, sdo_oe, sck_m, miso, ss_n;
  wire sck_w = sck_oe ? sck_o : sck_m;
  int fails = 0;
  int compares = 0;
  logic [7:0] ra [7] =
    '{OFS_STAT, OFS_CTRL, OFS_DIR_C, OFS_DIR_A, OFS_IRQ_STAT, OFS_IRQ_EN, 8'h55};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
  always #2.5 sys_clk = ~sys_clk;
  spi_port spi_port_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(miso),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .ss_n_i(ss_n)
  );
  spi_far_end spi_far_end_inst (
    .sck_w(sck_w), .mosi(sdo_o), .sck_m(sck_m), .miso(miso), .ss_n(ss_n)
  );
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input string name, input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(name, e, rdata);
  endtask
  // Bounded: the slowest rate needs about a thousand cycles
  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 2000)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (irq !== 1'b1)
    begin
      fails++;
      $display("unexpected irq: expected 1, seen %b", irq);
      conclude();
    end
  endtask
  function automatic int half_of(input int m);
    return int'((m == 0) ? HALF_DIV4 : (m == 1) ? HALF_DIV16 :
      (m == 2) ? HALF_DIV64 : HALF_DIV128);
  endfunction
  function automatic logic [7:0] ctrl_val(input int m, input logic p, input logic en);
    logic [7:0] v;
    v = 8'(m);
    v[CTRL_CPOL] = p;
    v[CTRL_EN] = en;
    return v;
  endfunction
  task automatic cfg(input int m, input logic p, input logic [7:0] d);
    wr_reg(OFS_CTRL, 8'h00);
    wr_reg(OFS_CTRL, ctrl_val(m, p, 1'b0));
    wr_reg(OFS_CTRL, ctrl_val(m, p, 1'b1));
    spi_far_end_inst.load(p, d);
  endtask
  initial
  begin
    logic [7:0] tx;
    logic [7:0] fx;
    logic p;
    int n;
    int h;
    void'($urandom(32'h2a75));
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1 chk("pin drive", 8'h00, {6'h0, sck_oe, sdo_oe});
    for (int i = 0; i < 7; i++) rd_reg("reset value", ra[i], rv[i]);
    wr_reg(OFS_STAT, 8'hff);
    rd_reg("status write", OFS_STAT, 8'h00);
    wr_reg(OFS_IRQ_EN, 8'h01);
    wr_reg(OFS_DIR_C, 8'hd7);
    $display("test reset done");
    for (int m = 0; m < 6; m++)
    begin
      p = 1'($urandom_range(1));
      tx = (m == 0) ? 8'h80 : 8'($urandom);
      fx = (m == 0) ? 8'h01 : 8'($urandom);
      if (m == 4) wr_reg(OFS_DIR_C, 8'hdf);
      cfg(m, p, fx);
      h = half_of(m);
      if (m < 4)
      begin
        chk("sck idle", 8'(p), 8'(sck_o));
        chk("sck drive", 8'h01, 8'(sck_oe));
        wr_reg(OFS_BUF, tx);
        // A second write while busy is refused and only flags the collision
        if (m == 3) wr_reg(OFS_BUF, ~tx);
        wait_irq(n);
        n = n + ((m == 3) ? 2 : 0);
        chk("rate", 8'h01, 8'(n >= 16 * h && n <= 16 * h + 4));
        if (m == 3) rd_reg("collision", OFS_CTRL, ctrl_val(m, p, 1'b1) | 8'h80);
      end
      else
      begin
        chk("sck drive", 8'h00, 8'(sck_oe));
        chk("data drive", 8'(m == 5), 8'(sdo_oe));
        wr_reg(OFS_BUF, tx);
        // A partial frame cut short by select must leave no stale bits behind
        if (m == 4)
        begin
          spi_far_end_inst.frame(3, 1'b1);
          spi_far_end_inst.load(p, fx);
          // Let the high select reach the engine before the byte is loaded again
          repeat (4) @(posedge sys_clk);
          wr_reg(OFS_BUF, tx);
        end
        spi_far_end_inst.frame(8, m == 4);
        wait_irq(n);
      end
      rd_reg("status full", OFS_STAT, 8'h01);
      rd_reg("irq status", OFS_IRQ_STAT, (m == 3) ? 8'h05 : 8'h01);
      wr_reg(OFS_IRQ_EN, 8'h00);
      #1 chk("irq masked", 8'h00, 8'(irq));
      wr_reg(OFS_IRQ_EN, 8'h01);
      #1 chk("irq raised", 8'h01, 8'(irq));
      wr_reg(OFS_IRQ_CLR, 8'h07);
      #1 chk("irq cleared", 8'h00, 8'(irq));
      rd_reg("rx byte", OFS_BUF, fx);
      rd_reg("status empty", OFS_STAT, 8'h00);
      chk("far rx", tx, spi_far_end_inst.rx);
      $display("test mode %0d done", m);
    end
    wr_reg(OFS_CTRL, 8'h00);
    #1 chk("pin drive", 8'h00, {6'h0, sck_oe, sdo_oe});
    wr_reg(OFS_BUF, 8'h5a);
    repeat (200) @(posedge sys_clk);
    #1 chk("no transfer", 8'h00, 8'(irq));
    rd_reg("status idle", OFS_STAT, 8'h00);
    $display("test disable done");
    conclude();
  end
endmodule
